// ### design/transient_pkg.sv
// Purpose: Shared constants and types of the transient event detector.
// Assumes: Acceleration samples arrive as signed 8-bit at 0.063g per LSB.
// Notes: Register offsets are byte addresses on the register port.
package transient_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_OFFSET = 8'h1d;
	localparam logic [7:0] SRC_OFFSET = 8'h1e;
	localparam logic [7:0] THR_OFFSET = 8'h1f;
	localparam logic [7:0] CNT_OFFSET = 8'h20;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] SRC_RESET = 8'h00;
	localparam logic [7:0] THR_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int THR_MODE_BIT = 7;
	localparam int THR_LEVEL_MSB = 6;
	localparam int CFG_LATCH_BIT = 4;
	localparam int CFG_Z_EN_BIT = 3;
	localparam int CFG_Y_EN_BIT = 2;
	localparam int CFG_X_EN_BIT = 1;
	localparam int CFG_BYPASS_BIT = 0;

	// Highest threshold count with the low-noise setting (4g)
	localparam logic [6:0] LOW_NOISE_MAX_LEVEL = 7'h3f;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int STEP_BASE_US = 1250;
	localparam int CLK_FREQ_KHZ = 40000;
	localparam int UNIT_CYCLES = STEP_BASE_US * CLK_FREQ_KHZ / 1000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_LOW_NOISE = 2'h1,
		MODE_HIGH_RES = 2'h2,
		MODE_LOW_POWER = 2'h3
	} os_mode_e;

	typedef struct packed {
		logic latch_enable;
		logic z_detect_enable;
		logic y_detect_enable;
		logic x_detect_enable;
		logic highpass_bypass;
	} tcfg_s;

	typedef struct packed {
		logic rsvd;
		logic event_active;
		logic z_axis_event;
		logic z_pol;
		logic y_axis_event;
		logic y_pol;
		logic x_axis_event;
		logic x_pol;
	} tsrc_s;

	// Step length in units of 1.25 ms; rate code 0 = 800 Hz ... 7 = 1.56 Hz
	function automatic logic [7:0] step_units(input logic [2:0] rate,
		input os_mode_e mode);
		logic [7:0] u;
		case (rate)
			3'h0: u = 8'h01;
			3'h1: u = 8'h02;
			3'h2: u = 8'h04;
			3'h3: u = 8'h08;
			3'h4: u = 8'h10;
			3'h5: u = 8'h40;
			default: u = 8'h80;
		endcase
		case (mode)
			MODE_NORMAL: if (u > 8'h10) u = 8'h10;
			MODE_LOW_NOISE: if (u > 8'h40) u = 8'h40;
			MODE_HIGH_RES: if (u > 8'h02) u = 8'h02;
			default: ;
		endcase
		return u;
	endfunction : step_units

endpackage : transient_pkg

// ### design/debounce_step_timer.sv
// Purpose: Debounce step pulse generator following rate and oversampling.
// Assumes: Rate and mode are steady while detection runs.
// Notes: One pulse per step, a step is a whole number of 1.25 ms units.
`timescale 1ns/1ps
module debounce_step_timer #(
	parameter int UNIT_CYCLES = transient_pkg::UNIT_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Timing selection
	input wire logic [2:0] sample_rate_i,
	input wire transient_pkg::os_mode_e os_mode_i,
	// Step pulse
	output logic step_o
);
	logic [31:0] cyc_ff, nxt_cyc;
	logic [7:0] unit_ff, nxt_unit;
	logic step_ff, nxt_step;
	logic [7:0] units;

	always_comb begin
		units = transient_pkg::step_units(sample_rate_i, os_mode_i);
		nxt_cyc = cyc_ff + 32'h1;
		nxt_unit = unit_ff;
		nxt_step = 1'b0;
		if (cyc_ff >= 32'(UNIT_CYCLES - 1)) begin
			nxt_cyc = 32'h0;
			if (unit_ff + 8'h1 >= units) begin
				nxt_unit = 8'h0;
				nxt_step = 1'b1;
			end else begin
				nxt_unit = unit_ff + 8'h1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cyc_ff <= 32'h0;
			unit_ff <= 8'h0;
			step_ff <= 1'b0;
		end else begin
			cyc_ff <= nxt_cyc;
			unit_ff <= nxt_unit;
			step_ff <= nxt_step;
		end
	end

	assign step_o = step_ff;
endmodule : debounce_step_timer

// ### design/axis_debouncer.sv
// Purpose: One axis of threshold compare and debounce counting.
// Assumes: Sample is signed, 0.063g per LSB, full 8g span.
// Notes: Detect level and sign update on a step pulse, or clear at once when the axis is disabled.
`timescale 1ns/1ps
module axis_debouncer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic step_i,
	input wire logic enable_i,
	input wire logic debounce_mode_i,
	input wire logic [6:0] level_i,
	input wire logic [7:0] count_i,
	// Sample
	input wire logic signed [7:0] sample_i,
	// Result
	output logic detect_o,
	output logic sign_o
);
	logic [7:0] cnt_ff, nxt_cnt;
	logic det_ff, nxt_det;
	logic sgn_ff, nxt_sgn;
	logic [7:0] mag;
	logic cond;

	always_comb begin
		mag = sample_i[7] ? 8'(-sample_i) : 8'(sample_i);
		cond = enable_i && (mag > {1'b0, level_i});
		nxt_cnt = cnt_ff;
		nxt_det = det_ff;
		nxt_sgn = sgn_ff;
		if (step_i) begin
			if (cond) begin
				nxt_cnt = (cnt_ff >= count_i) ? count_i : cnt_ff + 8'h1;
			end else if (debounce_mode_i) begin
				nxt_cnt = 8'h0;
			end else if (cnt_ff != 8'h0) begin
				nxt_cnt = cnt_ff - 8'h1;
			end
			nxt_det = cond && (nxt_cnt >= count_i);
			nxt_sgn = cond ? sample_i[7] : 1'b0;
		end
		// Disabled axis drops its detection at once
		if (!enable_i) begin
			nxt_cnt = 8'h0;
			nxt_det = 1'b0;
			nxt_sgn = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cnt_ff <= 8'h0;
			det_ff <= 1'b0;
			sgn_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			det_ff <= nxt_det;
			sgn_ff <= nxt_sgn;
		end
	end

	assign detect_o = det_ff;
	assign sign_o = sgn_ff;
endmodule : axis_debouncer

// ### design/transient_event_detector.sv
// Purpose: Transient acceleration event detector with source register.
// Assumes: Samples at 0.063g/LSB; register port strobes are one cycle.
// Notes: Read data appears one cycle after the read strobe.
// Function
// - Event active is set while any axis event flag is set, else zero.
// - Axis event flag sets when axis magnitude exceeds the threshold.
// - Polarity bit records sign of triggering acceleration, 1 for negative.
// - With latching on, active flag freezes all source bits until read.
// - Reading the source register clears every bit not set again by a detection in that cycle.
// - Threshold is compared against high-pass filtered data.
// - Top threshold bit picks decrement (0) or clear (1) when condition lapses.
// - Threshold is seven unsigned bits at 0.063g per count, 8g top.
// - Comparison spans full 8g whatever output full scale is chosen.
// - Low-noise setting caps reachable threshold at 4g.
// - Count register sets steps needed before the event, consecutive only in clear mode.
// - Step period follows rate and mode, 1.25 ms at 800 Hz.
// - Latch enable holds flags until read, otherwise they follow detection.
// - Each axis has an enable; disabled axes detect nothing.
// - Bypass bit feeds unfiltered data to the comparator.
`timescale 1ns/1ps
module transient_event_detector #(
	parameter int UNIT_CYCLES = transient_pkg::UNIT_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Device settings
	input wire logic [2:0] sample_rate_i,
	input wire transient_pkg::os_mode_e os_mode_i,
	input wire logic low_noise_i,
	// Acceleration, index 0 = X, 1 = Y, 2 = Z
	input wire logic [2:0][7:0] hpf_data_i,
	input wire logic [2:0][7:0] raw_data_i,
	// Status
	output logic event_active_o
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	transient_pkg::tcfg_s cfg_ff, nxt_cfg;
	logic [7:0] thr_ff, nxt_thr;
	logic [7:0] cnt_ff, nxt_cnt;
	transient_pkg::tsrc_s src_ff, nxt_src;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [2:0][7:0] smp_ff, nxt_smp;

	logic step;
	logic [2:0] det;
	logic [2:0] sgn;
	logic [2:0] en;
	logic [6:0] level;
	logic rd_src;
	logic hold;

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_thr = thr_ff;
		nxt_cnt = cnt_ff;
		if (reg_wr_i) begin
			case (reg_addr_i)
				transient_pkg::CFG_OFFSET:
					nxt_cfg = transient_pkg::tcfg_s'(reg_wdata_i[4:0]);
				transient_pkg::THR_OFFSET: nxt_thr = reg_wdata_i;
				transient_pkg::CNT_OFFSET: nxt_cnt = reg_wdata_i;
				default: ;
			endcase
		end
		nxt_rdata = rdata_ff;
		if (reg_rd_i) begin
			case (reg_addr_i)
				transient_pkg::CFG_OFFSET: nxt_rdata = {3'h0, cfg_ff};
				transient_pkg::SRC_OFFSET: nxt_rdata = src_ff;
				transient_pkg::THR_OFFSET: nxt_rdata = thr_ff;
				transient_pkg::CNT_OFFSET: nxt_rdata = cnt_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Data selection and threshold
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			nxt_smp[i] = cfg_ff.highpass_bypass ? raw_data_i[i]
				: hpf_data_i[i];
		end
		level = thr_ff[transient_pkg::THR_LEVEL_MSB:0];
		if (low_noise_i && level > transient_pkg::LOW_NOISE_MAX_LEVEL) begin
			level = transient_pkg::LOW_NOISE_MAX_LEVEL;
		end
		en = {cfg_ff.z_detect_enable, cfg_ff.y_detect_enable,
			cfg_ff.x_detect_enable};
	end

	// ----------------------------------------------------------------
	// Step timer and per-axis detectors
	// ----------------------------------------------------------------
	debounce_step_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.sample_rate_i(sample_rate_i),
		.os_mode_i(os_mode_i),
		.step_o(step)
	);

	for (genvar g = 0; g < 3; g++) begin : g_axis
		axis_debouncer u_axis (
			.mclk_i(mclk_i),
			.sys_rst_i(sys_rst_i),
			.step_i(step),
			.enable_i(en[g]),
			.debounce_mode_i(thr_ff[transient_pkg::THR_MODE_BIT]),
			.level_i(level),
			.count_i(cnt_ff),
			.sample_i(smp_ff[g]),
			.detect_o(det[g]),
			.sign_o(sgn[g])
		);
	end

	// ----------------------------------------------------------------
	// Source register
	// ----------------------------------------------------------------
	always_comb begin
		rd_src = reg_rd_i && (reg_addr_i == transient_pkg::SRC_OFFSET);
		hold = cfg_ff.latch_enable && src_ff.event_active && !rd_src;
		nxt_src = src_ff;
		if (!hold) begin
			// A detection in the read cycle wins over the clear
			nxt_src.x_axis_event = det[0];
			nxt_src.y_axis_event = det[1];
			nxt_src.z_axis_event = det[2];
			nxt_src.x_pol = det[0] ? sgn[0] : (rd_src ? 1'b0 : src_ff.x_pol);
			nxt_src.y_pol = det[1] ? sgn[1] : (rd_src ? 1'b0 : src_ff.y_pol);
			nxt_src.z_pol = det[2] ? sgn[2] : (rd_src ? 1'b0 : src_ff.z_pol);
		end
		nxt_src.rsvd = 1'b0;
		nxt_src.event_active = nxt_src.x_axis_event
			|| nxt_src.y_axis_event || nxt_src.z_axis_event;
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cfg_ff <= transient_pkg::tcfg_s'(transient_pkg::CFG_RESET[4:0]);
			thr_ff <= transient_pkg::THR_RESET;
			cnt_ff <= transient_pkg::CNT_RESET;
			src_ff <= transient_pkg::SRC_RESET;
			rdata_ff <= 8'h00;
			smp_ff <= '0;
		end else begin
			cfg_ff <= nxt_cfg;
			thr_ff <= nxt_thr;
			cnt_ff <= nxt_cnt;
			src_ff <= nxt_src;
			rdata_ff <= nxt_rdata;
			smp_ff <= nxt_smp;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign event_active_o = src_ff.event_active;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_active_summary;
		src_ff.event_active == (src_ff.x_axis_event || src_ff.y_axis_event
			|| src_ff.z_axis_event);
	endproperty
	a_active_summary: assert property (p_active_summary)
		else $error("event active does not match axis flags");

	property p_flag_needs_excess;
		$rose(det[0]) |-> $past(step) && ($past(smp_ff[0][7])
			? 8'(-$past(smp_ff[0])) : $past(smp_ff[0])) > {1'b0, $past(level)};
	endproperty
	a_flag_needs_excess: assert property (p_flag_needs_excess)
		else $error("x event raised without threshold excess");

	property p_polarity;
		!hold && det[1] |=> src_ff.y_pol == $past(sgn[1]);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("y polarity not taken from sign");

	property p_freeze;
		cfg_ff.latch_enable && src_ff.event_active && !rd_src
			|=> $stable(src_ff);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("source bits changed while frozen");

	property p_read_clear;
		rd_src && det == 3'h0
			|=> src_ff == transient_pkg::SRC_RESET;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("source not cleared by read");

	property p_data_select;
		##1 smp_ff[2] == ($past(cfg_ff.highpass_bypass) ? $past(raw_data_i[2])
			: $past(hpf_data_i[2]));
	endproperty
	a_data_select: assert property (p_data_select)
		else $error("wrong data routed to comparator");

	property p_low_noise_cap;
		low_noise_i |-> level <= 7'h3f;
	endproperty
	a_low_noise_cap: assert property (p_low_noise_cap)
		else $error("low-noise threshold above 4g");

	property p_full_span;
		!low_noise_i |-> level == thr_ff[6:0];
	endproperty
	a_full_span: assert property (p_full_span)
		else $error("threshold not full 7-bit span");

	property p_disabled_axis;
		!en[0] ##1 !en[0] |-> !det[0];
	endproperty
	a_disabled_axis: assert property (p_disabled_axis)
		else $error("disabled x axis raised detection");

	property p_follow_live;
		!cfg_ff.latch_enable ##1 !cfg_ff.latch_enable
			|-> src_ff.z_axis_event == $past(det[2]);
	endproperty
	a_follow_live: assert property (p_follow_live)
		else $error("unlatched z flag does not follow detection");

	property p_count_zero_event;
		step && cnt_ff == 8'h00 && en[0] && det[0] == 1'b0
			&& g_axis[0].u_axis.cond |=> det[0];
	endproperty
	a_count_zero_event: assert property (p_count_zero_event)
		else $error("count zero did not raise at once");

	property p_counter_saturates;
		step |=> g_axis[0].u_axis.cnt_ff <= $past(cnt_ff)
			|| g_axis[0].u_axis.cnt_ff < $past(g_axis[0].u_axis.cnt_ff);
	endproperty
	a_counter_saturates: assert property (p_counter_saturates)
		else $error("debounce counter beyond count");

	property p_clear_mode;
		step && thr_ff[7] && !g_axis[0].u_axis.cond
			|=> g_axis[0].u_axis.cnt_ff == 8'h00;
	endproperty
	a_clear_mode: assert property (p_clear_mode)
		else $error("clear mode did not zero counter");

	property p_step_800;
		sample_rate_i == 3'h0 && $stable(sample_rate_i) && step
			|=> !step [*8];
	endproperty
	a_step_800: assert property (p_step_800)
		else $error("steps closer than one unit");

	property p_event_sets_active;
		(|det) |=> event_active_o;
	endproperty
	a_event_sets_active: assert property (p_event_sets_active)
		else $error("axis detection did not set event active");

	property p_read_data;
		rd_src |=> reg_rdata_o == $past(src_ff);
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("source read data not the pre-clear value");

	property p_rdata_stands;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands)
		else $error("read data changed without a read");

	property p_disabled_clears;
		!en[1] |=> !det[1];
	endproperty
	a_disabled_clears: assert property (p_disabled_clears)
		else $error("disabled y axis kept its detection");

	c_latched_event: cover property (cfg_ff.latch_enable
		&& $rose(src_ff.event_active));
	c_read_clear: cover property (rd_src && src_ff.event_active);
	c_negative_event: cover property ($rose(src_ff.x_pol));
	c_decrement: cover property (step && !thr_ff[7]
		&& g_axis[0].u_axis.cnt_ff != 8'h00 && !g_axis[0].u_axis.cond);
endmodule : transient_event_detector

// ### sim/tb.sv
// Purpose: Self-checking bench for the transient event detector.
// Assumes: Short step unit of 20 clocks; steps aligned to reset release.
// Notes: Debounce stimulus changes mid-step so step phase never decides its results.
`timescale 1ns/1ps
module tb;
	localparam int UNIT = 20;
	localparam logic [7:0] CFG = transient_pkg::CFG_OFFSET;
	localparam logic [7:0] SRC = transient_pkg::SRC_OFFSET;
	localparam logic [7:0] THR = transient_pkg::THR_OFFSET;
	localparam logic [7:0] CNT = transient_pkg::CNT_OFFSET;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic [2:0] sample_rate_i = 3'h0;
	transient_pkg::os_mode_e os_mode_i = transient_pkg::MODE_NORMAL;
	logic low_noise_i = 1'b0;
	logic [2:0][7:0] hpf_data_i = '0;
	logic [2:0][7:0] raw_data_i = '0;
	logic event_active_o;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int lat = 0;
	logic [7:0] rd_val;
	logic [2:0] rates [5] = '{3'h0, 3'h2, 3'h7, 3'h5, 3'h6};
	transient_pkg::os_mode_e modes [5] = '{transient_pkg::MODE_NORMAL,
		transient_pkg::MODE_NORMAL, transient_pkg::MODE_HIGH_RES,
		transient_pkg::MODE_LOW_NOISE, transient_pkg::MODE_LOW_POWER};
	int units [5] = '{1, 4, 2, 64, 128};

	always #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= sys_rst_i ? 0 : cyc + 1;

	transient_event_detector #(.UNIT_CYCLES(UNIT)) uut (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.sample_rate_i(sample_rate_i),
		.os_mode_i(os_mode_i),
		.low_noise_i(low_noise_i),
		.hpf_data_i(hpf_data_i),
		.raw_data_i(raw_data_i),
		.event_active_o(event_active_o)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic chk_act(input logic exp);
		check("event_active_o", {7'h00, exp}, {7'h00, event_active_o});
	endtask : chk_act

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		tick(1);
		rd_val = reg_rdata_o;
	endtask : rd

	task automatic rdc(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		rd(a);
		check(what, exp, rd_val);
	endtask : rdc

	task automatic wait_ev(input int lim);
		lat = 0;
		while (event_active_o !== 1'b1) begin
			if (lat >= lim) begin
				miscompares++;
				$display("CHECK FAILED event_active_o expected 1 seen 0");
				stop_test();
			end
			tick(1);
			lat++;
		end
	endtask : wait_ev

	// Park stimulus changes halfway between step pulses
	task automatic wait_mid();
		for (int i = 0; i < UNIT && cyc % UNIT != UNIT / 2; i++)
			tick(1);
	endtask : wait_mid

	task automatic xset(input logic [7:0] h, input logic [7:0] r);
		hpf_data_i[0] = h;
		raw_data_i[0] = r;
	endtask : xset

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		tick(3);
		sys_rst_i = 1'b0;
		rdc("cfg reset", CFG, 8'h00);
		rdc("src reset", SRC, 8'h00);
		rdc("thr reset", THR, 8'h00);
		rdc("cnt reset", CNT, 8'h00);
		rdc("unmapped", 8'h21, 8'h00);
		wr(CFG, 8'hff);
		rdc("cfg rw", CFG, 8'h1f);
		wr(SRC, 8'hff);
		rdc("src read only", SRC, 8'h00);
		wr(THR, 8'h8a);
		rdc("thr rw", THR, 8'h8a);
		wr(CNT, 8'ha5);
		rdc("cnt rw", CNT, 8'ha5);
		$display("test registers done");

		// Latched negative Y event, X disabled, Z held back until read
		wr(CFG, 8'h1c);
		wr(THR, 8'h0a);
		wr(CNT, 8'h00);
		hpf_data_i = {8'h00, 8'hec, 8'h50};
		wait_ev(3 * UNIT);
		hpf_data_i = {8'h20, 8'h00, 8'h00};
		tick(3 * UNIT);
		chk_act(1'b1);
		rdc("src latched", SRC, 8'h4c);
		hpf_data_i = '0;
		tick(3 * UNIT);
		rdc("src late z", SRC, 8'h60);
		rdc("src cleared", SRC, 8'h00);
		chk_act(1'b0);
		$display("test latched done");

		// Live X: equal is not above, one more is
		wr(CFG, 8'h02);
		xset(8'h0a, 8'h00);
		tick(3 * UNIT);
		chk_act(1'b0);
		xset(8'h0b, 8'h00);
		wait_ev(3 * UNIT);
		rdc("src live", SRC, 8'h42);
		xset(8'h00, 8'h00);
		tick(2 * UNIT);
		chk_act(1'b0);
		rd(SRC);
		$display("test live done");

		// Filter bypass selects the raw sample
		wr(CFG, 8'h03);
		xset(8'h00, 8'h90);
		wait_ev(3 * UNIT);
		rdc("src bypass", SRC, 8'h43);
		xset(8'h90, 8'h00);
		tick(2 * UNIT);
		chk_act(1'b0);
		wr(CFG, 8'h02);
		wait_ev(3 * UNIT);
		xset(8'h00, 8'h00);
		tick(2 * UNIT);
		rd(SRC);
		$display("test bypass done");

		// Full span and low-noise cap
		wr(THR, 8'h7f);
		xset(8'h64, 8'h00);
		tick(3 * UNIT);
		chk_act(1'b0);
		low_noise_i = 1'b1;
		wait_ev(3 * UNIT);
		low_noise_i = 1'b0;
		wr(THR, 8'h7e);
		xset(8'h7f, 8'h00);
		tick(2 * UNIT);
		chk_act(1'b1);
		xset(8'h00, 8'h00);
		tick(2 * UNIT);
		rd(SRC);
		$display("test span done");

		// Debounce lapse: decrement versus clear, then saturation
		wr(CNT, 8'h03);
		for (int m = 0; m < 2; m++) begin
			wr(THR, {m[0], 7'h0a});
			wait_mid();
			xset(8'h20, 8'h00);
			tick(2 * UNIT);
			xset(8'h00, 8'h00);
			tick(UNIT);
			xset(8'h20, 8'h00);
			tick(2 * UNIT);
			chk_act(~m[0]);
			tick(UNIT);
			chk_act(1'b1);
			xset(8'h00, 8'h00);
			tick(4 * UNIT);
			rd(SRC);
		end
		wr(THR, 8'h0a);
		wr(CNT, 8'h02);
		wait_mid();
		xset(8'h20, 8'h00);
		tick(5 * UNIT);
		xset(8'h00, 8'h00);
		tick(UNIT);
		chk_act(1'b0);
		xset(8'h20, 8'h00);
		tick(UNIT);
		chk_act(1'b1);
		$display("test debounce done");

		// Step period per rate and mode, two steps needed
		wr(THR, 8'h8a);
		for (int i = 0; i < 5; i++) begin
			xset(8'h00, 8'h00);
			sample_rate_i = rates[i];
			os_mode_i = modes[i];
			tick(8 * UNIT * units[i]);
			rd(SRC);
			xset(8'h20, 8'h00);
			wait_ev(2 * UNIT * units[i] + 8);
			check("step period", 8'h01, {7'h00, lat > UNIT * units[i]});
		end
		$display("test step period done");
		stop_test();
	end
endmodule : tb
